// *** verification/amo_out_stage.sv ***
// Model of the analog output stage that follows the monitor codes
`timescale 1ns/10ps
`default_nettype none

module amo_out_stage (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] code1_in,
    input  wire logic [15:0] code2_in,
    input  wire logic        update_in,
    output logic      [15:0] held1_out,
    output logic      [15:0] held2_out,
    output var int           period_out
);
    int cnt;

    // Latches only on the pulse, so mid-period glitches never reach the DAC
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
            period_out <= 0;
            held1_out <= 16'h0000;
            held2_out <= 16'h0000;
        end else if (update_in) begin
            held1_out <= code1_in;
            held2_out <= code2_in;
            period_out <= cnt + 1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench of the analog monitor block
`timescale 1ns/10ps
`default_nettype none

module tb;
    import amo_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0;
    logic ar_valid = 1'h0, r_ready = 1'h0, enc_inc20 = 1'h0, enc_abs = 1'h0, phase_z = 1'h0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0000_0000;
    logic [31:0] val [0:21];
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, upd;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    logic [15:0] mon1, mon2, held1, held2;
    int period, num_errors = 0, n_checks = 0, cyc = 0, z_seen = 0, fixed = 0;
    integer seed = 32'h8a4f;

    always #10 clk = ~clk;
    initial for (int i = 0; i < 22; i++) val[i] = 32'h0000_0000;

    amo_analog_monitor #(.REFRESH_CYCLES(20)) dut (
        .CLOCK_IN(clk), .RESETN_IN(rst_n),
        .AXI_AWVALID_IN(aw_valid), .AXI_AWREADY_OUT(aw_ready), .AXI_AWADDR_IN(aw_addr),
        .AXI_WVALID_IN(w_valid), .AXI_WREADY_OUT(w_ready), .AXI_WDATA_IN(w_data),
        .AXI_WSTRB_IN(4'hF), .AXI_BVALID_OUT(b_valid), .AXI_BREADY_IN(b_ready),
        .AXI_BRESP_OUT(b_resp), .AXI_ARVALID_IN(ar_valid), .AXI_ARREADY_OUT(ar_ready),
        .AXI_ARADDR_IN(ar_addr), .AXI_RVALID_OUT(r_valid), .AXI_RREADY_IN(r_ready),
        .AXI_RDATA_OUT(r_data), .AXI_RRESP_OUT(r_resp),
        .MOTOR_SPEED_IN(val[0]), .POS_CMD_SPEED_IN(val[1]), .INT_CMD_SPEED_IN(val[2]),
        .SPEED_CMD_IN(val[3]), .TORQUE_CMD_IN(val[4]), .CMD_POS_ERR_IN(val[5]),
        .ENC_POS_ERR_IN(val[6]), .FULL_CLOSE_ERR_IN(val[7]), .HYBRID_ERR_IN(val[8]),
        .PN_VOLTAGE_IN(val[9]), .REGEN_LOAD_IN(val[10]), .OVERLOAD_IN(val[11]),
        .FWD_TORQUE_LIM_IN(val[12]), .REV_TORQUE_LIM_IN(val[13]), .SPEED_LIMIT_IN(val[14]),
        .INERTIA_RATIO_IN(val[15]), .ENC_TEMP_IN(val[19]), .DRIVE_TEMP_IN(val[20]),
        .ENC_ROT_DATA_IN(val[21]), .ENC_INC20_IN(enc_inc20), .ENC_ABS_IN(enc_abs),
        .PHASE_Z_IN(phase_z), .MON1_CODE_OUT(mon1), .MON2_CODE_OUT(mon2), .MON_UPDATE_OUT(upd)
    );

    amo_out_stage stage (
        .clk_in(clk), .rst_n_in(rst_n), .code1_in(mon1), .code2_in(mon2),
        .update_in(upd), .held1_out(held1), .held2_out(held2), .period_out(period)
    );

    task automatic report_and_stop();
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Hangs are cut here rather than in every wait loop
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 40000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // Behavioural reference, millivolts sign-extended to a word
    function automatic logic [31:0] exp_code(int item, int scale, int meth, int rot);
        longint v, g, mv, lo;
        v = (item <= 21) ? longint'($signed(val[item])) : 0;
        case (item)
            0, 1, 2, 3, 14, 15: g = 500;
            4, 10, 11, 12, 13: g = 33;
            5, 6, 7, 8: g = 3000;
            9: g = 80;
            19, 20: g = 10;
            21: g = 110000;
            default: begin
                g = 1;
                v = 0;
            end
        endcase
        if (scale != 0) g = scale;
        if ((item == 19 && !enc_inc20) || (item == 21 && !enc_abs && z_seen == 0)) v = 0;
        if (rot != 0 && (item <= 8 || (item == 21 && !enc_abs))) v = -v;
        mv = v * 1000 / g;
        if (meth == 1) mv = (mv < 0) ? -mv : mv;
        else if (meth == 2) mv = mv + 5000;
        lo = (meth == 1 || meth == 2) ? 0 : -10000;
        if (mv > 10000) mv = 10000;
        if (mv < lo) mv = lo;
        return mv[31:0];
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad, wd;
        ad = 0;
        wd = 0;
        aw_valid <= 1'h1;
        w_valid <= 1'h1;
        aw_addr <= a;
        w_data <= d;
        b_ready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && aw_ready === 1'h1) begin
                ad = 1;
                aw_valid <= 1'h0;
            end
            if (!wd && w_ready === 1'h1) begin
                wd = 1;
                w_valid <= 1'h0;
            end
        end
        do @(posedge clk); while (b_valid !== 1'h1);
        b_ready <= 1'h0;
        check("bresp", {30'h0000_0000, b_resp}, {30'h0000_0000, er});
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        ar_valid <= 1'h1;
        ar_addr <= a;
        r_ready <= 1'h1;
        do @(posedge clk); while (ar_ready !== 1'h1);
        ar_valid <= 1'h0;
        do @(posedge clk); while (r_valid !== 1'h1);
        r_ready <= 1'h0;
        check("rdata", r_data, ed);
        check("rresp", {30'h0000_0000, r_resp}, {30'h0000_0000, er});
        @(posedge clk);
    endtask

    task automatic run_case(input int s1, input int s2, input int c1, input int c2, input int m, input int r);
        logic [31:0] e1, e2;
        axi_wr(8'h00, s1, 2'h0);
        axi_wr(8'h04, c1, 2'h0);
        axi_wr(8'h08, s2, 2'h0);
        axi_wr(8'h0C, c2, 2'h0);
        axi_wr(8'h10, m, 2'h0);
        axi_wr(8'h14, r, 2'h0);
        // Directed cases keep their chosen inputs
        if (fixed == 0) for (int i = 0; i < 22; i++) val[i] <= $random(seed) % 4000;
        repeat (2) do @(posedge clk); while (upd !== 1'h1);
        @(posedge clk);
        e1 = exp_code(s1, c1, m, r);
        e2 = exp_code(s2, c2, m, r);
        check("mon1", {{16{mon1[15]}}, mon1}, e1);
        check("mon2", {{16{mon2[15]}}, mon2}, e2);
        check("held1", {16'h0000, held1}, {16'h0000, e1[15:0]});
        check("held2", {16'h0000, held2}, {16'h0000, e2[15:0]});
        check("period", period, 20);
        axi_rd(8'h1C, e1, 2'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        for (int a = 0; a < 24; a += 4) axi_rd(a[7:0], 32'h0000_0000, 2'h0);
        axi_rd(8'h40, 32'h0000_0000, 2'h2);
        axi_wr(8'h40, 32'h0000_0001, 2'h2);
        axi_wr(8'h04, 32'hFFFF_FFFF, 2'h0);
        axi_rd(8'h04, 32'h00FF_FFFF, 2'h0);
        for (int i = 0; i < 22; i++) begin
            enc_inc20 <= 1'($random(seed));
            enc_abs <= 1'($random(seed));
            run_case(i, 21 - i, 0, 0, 0, 0);
        end
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 2; r++) begin
                run_case(m, 5 + m, ($random(seed) & 32'h0000_07FF) + 1, 0, m, r);
            end
        end
        enc_abs <= 1'h0;
        run_case(21, 21, 0, 1000, 0, 0);
        axi_rd(8'h18, 32'h0000_0000, 2'h0);
        phase_z <= 1'h1;
        repeat (5) @(posedge clk);
        phase_z <= 1'h0;
        z_seen = 1;
        repeat (4) @(posedge clk);
        axi_rd(8'h18, 32'h0000_0001, 2'h0);
        run_case(21, 21, 0, 1000, 1, 1);
        enc_abs <= 1'h1;
        run_case(21, 0, 50, 0, 0, 1);
        fixed = 1;
        val[0] <= 32'h0000_01F4;
        val[4] <= 32'h0000_0032;
        val[21] <= 32'h0001_ADB0;
        run_case(0, 21, 0, 0, 0, 0);
        run_case(4, 21, 100, 0, 0, 0);
        run_case(17, 21, 0, 0, 0, 1);
        run_case(18, 21, 0, 0, 2, 1);
        report_and_stop();
    end
endmodule

`default_nettype wire

// *** verilog/amo_analog_monitor.sv ***
// Two-channel analog monitor front end with AXI4-Lite registers
// Behaviour
// - Both channel output codes are recomputed and refreshed once every 1 ms.
// - Two channels each have their own item select and scale, and share one output method.
// - A nonzero scale is the quantity, in the item's unit, that gives one volt of output.
// - A zero scale is replaced by the default gain of the selected item.
// - Codes 0 to 3 pick motor, position command, internal command and speed command speed, gain 500.
// - Codes 5 to 8 pick command, encoder, full closing and hybrid errors in pulses, gain 3000.
// - Codes 4 and 10 to 13 pick torque command, regeneration, overload and torque limits, gain 33.
// - Codes 19 and 20 pick encoder and drive temperature in Celsius, gain 10.
// - Code 21 picks single-rotation encoder data in pulses, gain 110000.
// - Position command speed is taken before the command filters, internal speed after them.
// - Encoder temperature is meaningful only with a 20-bit incremental encoder.
// - Signed data follow the rotation direction, except absolute single-rotation data, always CCW positive.
// - With an incremental encoder, single-rotation data are valid only after the first index pulse.
// - Encoder and full closing errors are in encoder units, command error in command pulse units.
// - Method 0 gives plus and minus 10 V, 1 gives 0 to 10 V, 2 gives 0 to 10 V centred at 5 V.
`timescale 1ns/10ps
`default_nettype none
`include "amo_defs.svh"

module amo_analog_monitor
    import amo_pkg::*;
#(
    parameter int REFRESH_CYCLES = `AMO_REFRESH_NS / `AMO_CLK_NS
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        AXI_AWVALID_IN,
    output logic             AXI_AWREADY_OUT,
    input  wire logic [7:0]  AXI_AWADDR_IN,
    input  wire logic        AXI_WVALID_IN,
    output logic             AXI_WREADY_OUT,
    input  wire logic [31:0] AXI_WDATA_IN,
    input  wire logic [3:0]  AXI_WSTRB_IN,
    output logic             AXI_BVALID_OUT,
    input  wire logic        AXI_BREADY_IN,
    output logic [1:0]       AXI_BRESP_OUT,
    input  wire logic        AXI_ARVALID_IN,
    output logic             AXI_ARREADY_OUT,
    input  wire logic [7:0]  AXI_ARADDR_IN,
    output logic             AXI_RVALID_OUT,
    input  wire logic        AXI_RREADY_IN,
    output logic [31:0]      AXI_RDATA_OUT,
    output logic [1:0]       AXI_RRESP_OUT,
    input  wire logic [31:0] MOTOR_SPEED_IN,
    input  wire logic [31:0] POS_CMD_SPEED_IN,
    input  wire logic [31:0] INT_CMD_SPEED_IN,
    input  wire logic [31:0] SPEED_CMD_IN,
    input  wire logic [31:0] TORQUE_CMD_IN,
    input  wire logic [31:0] CMD_POS_ERR_IN,
    input  wire logic [31:0] ENC_POS_ERR_IN,
    input  wire logic [31:0] FULL_CLOSE_ERR_IN,
    input  wire logic [31:0] HYBRID_ERR_IN,
    input  wire logic [31:0] PN_VOLTAGE_IN,
    input  wire logic [31:0] REGEN_LOAD_IN,
    input  wire logic [31:0] OVERLOAD_IN,
    input  wire logic [31:0] FWD_TORQUE_LIM_IN,
    input  wire logic [31:0] REV_TORQUE_LIM_IN,
    input  wire logic [31:0] SPEED_LIMIT_IN,
    input  wire logic [31:0] INERTIA_RATIO_IN,
    input  wire logic [31:0] ENC_TEMP_IN,
    input  wire logic [31:0] DRIVE_TEMP_IN,
    input  wire logic [31:0] ENC_ROT_DATA_IN,
    input  wire logic        ENC_INC20_IN,
    input  wire logic        ENC_ABS_IN,
    input  wire logic        PHASE_Z_IN,
    output logic [15:0]      MON1_CODE_OUT,
    output logic [15:0]      MON2_CODE_OUT,
    output logic             MON_UPDATE_OUT
);

    localparam logic [15:0] CNT_LAST = 16'(REFRESH_CYCLES - 1);

    amo_state_t s_q;
    amo_state_t s_d;

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Bit 32 flags an unmapped address
    function automatic logic [32:0] reg_word(input amo_state_t st, input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        unique case ({a[7:2], 2'b00})
            `AMO_OFS_SEL1:   r[4:0]  = st.sel[0];
            `AMO_OFS_SCALE1: r[23:0] = st.scale[0];
            `AMO_OFS_SEL2:   r[4:0]  = st.sel[1];
            `AMO_OFS_SCALE2: r[23:0] = st.scale[1];
            `AMO_OFS_METHOD: r[1:0]  = st.method;
            `AMO_OFS_ROTDIR: r[`AMO_ROTDIR_BIT] = st.rot;
            `AMO_OFS_STATUS: r[`AMO_STAT_ZSEEN_BIT] = st.z_seen;
            `AMO_OFS_CODE1:  r[31:0] = {{16{st.code[0][15]}}, st.code[0]};
            `AMO_OFS_CODE2:  r[31:0] = {{16{st.code[1][15]}}, st.code[1]};
            default:         r[32] = 1'b1;
        endcase
        return r;
    endfunction

    function automatic logic [23:0] default_gain(input logic [4:0] sel);
        logic [23:0] g;
        g = `AMO_GAIN_NONE;
        if (sel <= AMO_SPEED_CMD || sel == AMO_SPEED_LIMIT || sel == AMO_INERTIA) begin
            g = `AMO_GAIN_SPEED;
        end else if (sel >= AMO_CMD_POS_ERR && sel <= AMO_HYBRID_ERR) begin
            g = `AMO_GAIN_PULSE;
        end else if (sel == AMO_TORQUE_CMD || (sel >= AMO_REGEN_LOAD && sel <= AMO_REV_TLIM)) begin
            g = `AMO_GAIN_PERCENT;
        end else if (sel == AMO_PN_VOLTAGE) begin
            g = `AMO_GAIN_VOLT;
        end else if (sel == AMO_ENC_TEMP || sel == AMO_DRIVE_TEMP) begin
            g = `AMO_GAIN_TEMP;
        end else if (sel == AMO_ENC_ROT_DATA) begin
            g = `AMO_GAIN_ROT;
        end
        return g;
    endfunction

    always_comb begin
        logic [31:0] val;
        logic        ok;
        logic        dir_ok;
        logic [23:0] gain;
        logic signed [63:0] mv;
        logic signed [63:0] res;
        logic [32:0] rw;
        logic [31:0] wv;
        val    = 32'h0000_0000;
        ok     = 1'b0;
        dir_ok = 1'b0;
        gain   = `AMO_GAIN_NONE;
        mv     = 64'sh0;
        res    = 64'sh0;
        rw     = 33'h0_0000_0000;
        wv     = 32'h0000_0000;
        s_d    = s_q;

        // Index detect; first stage feeds only the second
        s_d.zsync = {s_q.zsync[1:0], PHASE_Z_IN};
        if (s_q.zsync[1] == s_q.zsync[2]) begin
            s_d.z_lvl = s_q.zsync[2];
        end
        if (s_q.z_lvl) begin
            s_d.z_seen = 1'b1;
        end

        // Refresh timer
        s_d.upd = (s_q.cnt == CNT_LAST);
        s_d.cnt = (s_q.cnt == CNT_LAST) ? 16'h0000 : s_q.cnt + 16'h0001;

        for (int c = 0; c < 2; c++) begin
            ok     = 1'b1;
            dir_ok = 1'b1;
            unique case (s_q.sel[c])
                AMO_MOTOR_SPEED:  val = MOTOR_SPEED_IN;
                AMO_POS_CMD_SPD:  val = POS_CMD_SPEED_IN;
                AMO_INT_CMD_SPD:  val = INT_CMD_SPEED_IN;
                AMO_SPEED_CMD:    val = SPEED_CMD_IN;
                AMO_TORQUE_CMD:   val = TORQUE_CMD_IN;
                AMO_CMD_POS_ERR:  val = CMD_POS_ERR_IN;
                AMO_ENC_POS_ERR:  val = ENC_POS_ERR_IN;
                AMO_FULL_CL_ERR:  val = FULL_CLOSE_ERR_IN;
                AMO_HYBRID_ERR:   val = HYBRID_ERR_IN;
                AMO_PN_VOLTAGE:   val = PN_VOLTAGE_IN;
                AMO_REGEN_LOAD:   val = REGEN_LOAD_IN;
                AMO_OVERLOAD:     val = OVERLOAD_IN;
                AMO_FWD_TLIM:     val = FWD_TORQUE_LIM_IN;
                AMO_REV_TLIM:     val = REV_TORQUE_LIM_IN;
                AMO_SPEED_LIMIT:  val = SPEED_LIMIT_IN;
                AMO_INERTIA:      val = INERTIA_RATIO_IN;
                AMO_ENC_TEMP: begin
                    val = ENC_TEMP_IN;
                    ok  = ENC_INC20_IN;
                end
                AMO_DRIVE_TEMP:   val = DRIVE_TEMP_IN;
                AMO_ENC_ROT_DATA: begin
                    val    = ENC_ROT_DATA_IN;
                    ok     = ENC_ABS_IN || s_q.z_seen;
                    dir_ok = !ENC_ABS_IN;
                end
                default: begin
                    val = 32'h0000_0000;
                    ok  = 1'b0;
                end
            endcase
            // Unsigned quantities keep their sign whatever the direction
            if (s_q.sel[c] > AMO_HYBRID_ERR && s_q.sel[c] != AMO_ENC_ROT_DATA) begin
                dir_ok = 1'b0;
            end
            gain = (s_q.scale[c] == `AMO_RST_SCALE) ? default_gain(s_q.sel[c]) : s_q.scale[c];
            mv = ok ? 64'($signed(val)) * $signed(`AMO_MV_PER_V) : 64'sh0;
            if (s_q.rot && dir_ok) begin
                mv = -mv;
            end
            mv = mv / $signed({40'h00_0000_0000, gain});
            // Wide compare before truncation avoids wrap
            unique case (s_q.method)
                AMO_UNIPOLAR: res = (mv < 0) ? -mv : mv;
                AMO_CENTERED: res = mv + $signed(`AMO_MV_CENTER);
                default:      res = mv;
            endcase
            if (res > $signed(`AMO_MV_FULL)) begin
                res = $signed(`AMO_MV_FULL);
            end else if (s_q.method != AMO_BIPOLAR && s_q.method != AMO_SPARE && res < 0) begin
                res = 64'sh0;
            end else if (res < -$signed(`AMO_MV_FULL)) begin
                res = -$signed(`AMO_MV_FULL);
            end
            if (s_q.cnt == CNT_LAST) begin
                s_d.code[c] = res[15:0];
            end
        end

        // Write channel
        if (AXI_AWVALID_IN && !s_q.aw_pend) begin
            s_d.aw_pend = 1'b1;
            s_d.awaddr  = AXI_AWADDR_IN;
        end
        if (AXI_WVALID_IN && !s_q.w_pend) begin
            s_d.w_pend = 1'b1;
            s_d.wdata  = AXI_WDATA_IN;
            s_d.wstrb  = AXI_WSTRB_IN;
        end
        if (s_q.bvalid && AXI_BREADY_IN) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_pend && s_q.w_pend && !s_q.bvalid) begin
            rw = reg_word(s_q, s_q.awaddr);
            wv = strb_merge(rw[31:0], s_q.wdata, s_q.wstrb);
            s_d.aw_pend = 1'b0;
            s_d.w_pend  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = rw[32] ? `AMO_RESP_SLVERR : `AMO_RESP_OKAY;
            unique case ({s_q.awaddr[7:2], 2'b00})
                `AMO_OFS_SEL1:   s_d.sel[0]   = wv[`AMO_SEL_MSB:0];
                `AMO_OFS_SCALE1: s_d.scale[0] = wv[`AMO_SCALE_MSB:0];
                `AMO_OFS_SEL2:   s_d.sel[1]   = wv[`AMO_SEL_MSB:0];
                `AMO_OFS_SCALE2: s_d.scale[1] = wv[`AMO_SCALE_MSB:0];
                `AMO_OFS_METHOD: s_d.method   = wv[`AMO_METHOD_MSB:0];
                `AMO_OFS_ROTDIR: s_d.rot      = wv[`AMO_ROTDIR_BIT];
                default: ;
            endcase
        end

        // Read channel
        if (s_q.rvalid && AXI_RREADY_IN) begin
            s_d.rvalid = 1'b0;
        end
        if (AXI_ARVALID_IN && !s_q.rvalid) begin
            rw = reg_word(s_q, AXI_ARADDR_IN);
            s_d.rvalid = 1'b1;
            s_d.rdata  = rw[31:0];
            s_d.rresp  = rw[32] ? `AMO_RESP_SLVERR : `AMO_RESP_OKAY;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            s_q        <= '0;
            s_q.sel    <= {`AMO_RST_SEL, `AMO_RST_SEL};
            s_q.scale  <= {`AMO_RST_SCALE, `AMO_RST_SCALE};
            s_q.method <= `AMO_RST_METHOD;
            s_q.rot    <= `AMO_RST_ROTDIR;
        end else begin
            s_q <= s_d;
        end
    end

    assign AXI_AWREADY_OUT = !s_q.aw_pend;
    assign AXI_WREADY_OUT  = !s_q.w_pend;
    assign AXI_BVALID_OUT  = s_q.bvalid;
    assign AXI_BRESP_OUT   = s_q.bresp;
    assign AXI_ARREADY_OUT = !s_q.rvalid;
    assign AXI_RVALID_OUT  = s_q.rvalid;
    assign AXI_RDATA_OUT   = s_q.rdata;
    assign AXI_RRESP_OUT   = s_q.rresp;
    assign MON1_CODE_OUT   = s_q.code[0];
    assign MON2_CODE_OUT   = s_q.code[1];
    assign MON_UPDATE_OUT  = s_q.upd;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);

    a_refresh_tick: assert property (s_q.cnt == CNT_LAST |=> MON_UPDATE_OUT && s_q.cnt == 16'h0000)
        else $error("update not issued at end of period");
    a_hold_between: assert property (s_q.cnt != CNT_LAST |=> $stable(MON1_CODE_OUT) && $stable(MON2_CODE_OUT))
        else $error("output changed between refreshes");
    a_default_gain: assert property (s_q.cnt == CNT_LAST && s_q.sel[0] == 5'h00 && s_q.scale[0] == 24'h00_0000
        && s_q.method == 2'h0 && !s_q.rot && MOTOR_SPEED_IN == 32'h0000_01F4 |=> MON1_CODE_OUT == 16'h03E8)
        else $error("default speed gain not applied");
    a_scale_unit: assert property (s_q.cnt == CNT_LAST && s_q.sel[0] == 5'h04 && s_q.scale[0] == 24'h00_0064
        && s_q.method == 2'h0 && !s_q.rot && TORQUE_CMD_IN == 32'h0000_0032 |=> MON1_CODE_OUT == 16'h01F4)
        else $error("scale per volt wrong");
    a_reserved_zero: assert property (s_q.cnt == CNT_LAST && s_q.sel[0] >= 5'h10 && s_q.sel[0] <= 5'h12
        && s_q.method == 2'h2 |=> MON1_CODE_OUT == 16'h1388)
        else $error("reserved item not at zero code");
    a_range_clamp: assert property ($signed(MON1_CODE_OUT) <= 16'sh2710 && $signed(MON1_CODE_OUT) >= -16'sh2710)
        else $error("code outside range");
    a_unipolar_pos: assert property (s_q.cnt == CNT_LAST && (s_q.method == 2'h1 || s_q.method == 2'h2)
        |=> !MON2_CODE_OUT[15])
        else $error("negative code in unipolar range");
    a_index_gate: assert property (s_q.cnt == CNT_LAST && s_q.sel[1] == 5'h15 && !ENC_ABS_IN && !s_q.z_seen
        && s_q.method == 2'h0 |=> MON2_CODE_OUT == 16'h0000)
        else $error("rotation data before index");
    a_abs_ccw: assert property (s_q.cnt == CNT_LAST && s_q.sel[1] == 5'h15 && ENC_ABS_IN && s_q.rot
        && s_q.scale[1] == 24'h00_0000 && s_q.method == 2'h0 && ENC_ROT_DATA_IN == 32'h0001_ADB0
        |=> MON2_CODE_OUT == 16'h03E8)
        else $error("absolute data direction flipped");
    a_bresp_hold: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
        else $error("write response dropped");

    c_update: cover property (MON_UPDATE_OUT);
    c_write: cover property (AXI_BVALID_OUT && AXI_BREADY_IN);
    c_read: cover property (AXI_RVALID_OUT && AXI_RREADY_IN);
    c_centered: cover property (MON_UPDATE_OUT && s_q.method == 2'h2);

endmodule

`default_nettype wire

// *** verilog/amo_defs.svh ***
// Constants of the analog monitor output block
`ifndef AMO_DEFS_SVH
`define AMO_DEFS_SVH

// Register byte offsets
`define AMO_OFS_SEL1        8'h00
`define AMO_OFS_SCALE1      8'h04
`define AMO_OFS_SEL2        8'h08
`define AMO_OFS_SCALE2      8'h0C
`define AMO_OFS_METHOD      8'h10
`define AMO_OFS_ROTDIR      8'h14
`define AMO_OFS_STATUS      8'h18
`define AMO_OFS_CODE1       8'h1C
`define AMO_OFS_CODE2       8'h20

// Field positions
`define AMO_SEL_MSB         4
`define AMO_SCALE_MSB       23
`define AMO_METHOD_MSB      1
`define AMO_ROTDIR_BIT      0
`define AMO_STAT_ZSEEN_BIT  0
`define AMO_CODE_MSB        15

// Reset values
`define AMO_RST_SEL         5'h00
`define AMO_RST_SCALE       24'h00_0000
`define AMO_RST_METHOD      2'h0
`define AMO_RST_ROTDIR      1'h0

// Default gains per volt
`define AMO_GAIN_SPEED      24'h00_01F4
`define AMO_GAIN_PERCENT    24'h00_0021
`define AMO_GAIN_PULSE      24'h00_0BB8
`define AMO_GAIN_VOLT       24'h00_0050
`define AMO_GAIN_TEMP       24'h00_000A
`define AMO_GAIN_ROT        24'h01_ADB0
`define AMO_GAIN_NONE       24'h00_0001

// Output codes in millivolts
`define AMO_MV_PER_V        64'h0000_0000_0000_03E8
`define AMO_MV_FULL         64'h0000_0000_0000_2710
`define AMO_MV_CENTER       64'h0000_0000_0000_1388

// Timing
`define AMO_CLK_NS          20
`define AMO_REFRESH_NS      1000000

// Bus responses
`define AMO_RESP_OKAY       2'h0
`define AMO_RESP_SLVERR     2'h2

`endif

// *** verilog/amo_pkg.sv ***
// Types of the analog monitor output block
`default_nettype none

package amo_pkg;

    typedef enum logic [1:0] {
        AMO_BIPOLAR  = 2'h0,
        AMO_UNIPOLAR = 2'h1,
        AMO_CENTERED = 2'h2,
        AMO_SPARE    = 2'h3
    } amo_method_t;

    typedef enum logic [4:0] {
        AMO_MOTOR_SPEED  = 5'h00,
        AMO_POS_CMD_SPD  = 5'h01,
        AMO_INT_CMD_SPD  = 5'h02,
        AMO_SPEED_CMD    = 5'h03,
        AMO_TORQUE_CMD   = 5'h04,
        AMO_CMD_POS_ERR  = 5'h05,
        AMO_ENC_POS_ERR  = 5'h06,
        AMO_FULL_CL_ERR  = 5'h07,
        AMO_HYBRID_ERR   = 5'h08,
        AMO_PN_VOLTAGE   = 5'h09,
        AMO_REGEN_LOAD   = 5'h0A,
        AMO_OVERLOAD     = 5'h0B,
        AMO_FWD_TLIM     = 5'h0C,
        AMO_REV_TLIM     = 5'h0D,
        AMO_SPEED_LIMIT  = 5'h0E,
        AMO_INERTIA      = 5'h0F,
        AMO_ENC_TEMP     = 5'h13,
        AMO_DRIVE_TEMP   = 5'h14,
        AMO_ENC_ROT_DATA = 5'h15
    } amo_item_t;

    typedef struct packed {
        logic [1:0][4:0]  sel;
        logic [1:0][23:0] scale;
        logic [1:0]       method;
        logic             rot;
        logic             aw_pend;
        logic [7:0]       awaddr;
        logic             w_pend;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic [15:0]      cnt;
        logic [2:0]       zsync;
        logic             z_lvl;
        logic             z_seen;
        logic             upd;
        logic [1:0][15:0] code;
    } amo_state_t;

endpackage

`default_nettype wire
